// ### spc_pkg.sv
// Package for the stop-mode power controller: map, fields, states and carriers
`default_nettype none

package spc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, 8-bit data)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PWR_CTRL = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_PERIPH_DIS = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_STOP_COUNT = 8'h04;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OSC_WDT_RC = 0;
	localparam int OSC_SEC = 1;
	localparam int OSC_XTAL = 2;
	localparam int PWR_LVD = 0;
	localparam int PWR_AMP_CMP = 1;
	localparam int PWR_WDT_LOGIC = 2;
	localparam int PWR_TIMER_STOP = 3;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_BO_OPT = 4;
	localparam int STAT_OSC_RDY = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] OSC_CTRL_RST = 8'h01;
	localparam logic [DATA_W-1:0] PWR_CTRL_RST = 8'h04;
	localparam logic [DATA_W-1:0] PERIPH_DIS_RST = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETTLE_MIN_NS = 2000;
	localparam int SETTLE_CYC = (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Modes and carriers
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_NORMAL = 4'h1,
		MODE_HALT = 4'h2,
		MODE_STOP = 4'h4,
		MODE_SETTLE = 4'h8
	} spc_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} spc_bus_t;

	typedef struct packed {
		logic primary_osc_en;
		logic precision_osc_en;
		logic xtal_pin_en;
		logic sysclk_en;
		logic cpu_run;
		logic pc_advance;
	} spc_core_t;

	typedef struct packed {
		logic wdt_rc_osc_en;
		logic wdt_logic_en;
		logic sec_osc_en;
		logic stop_timer_run;
		logic timer_clk_sec;
		logic bo_prot_en;
		logic lvd_en;
		logic amp_cmp_en;
	} spc_keep_t;

endpackage

`default_nettype wire

// ### spc_settle_timer.sv
// Oscillator settle timer: counts stable-ready cycles after a restart
`default_nettype none

module spc_settle_timer #(
	parameter int SETTLE_CYCLES = 250
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic run_in,
	input wire logic osc_ready_in,
	output logic done_out
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	if (SETTLE_CYCLES < 1) begin : g_chk
		$error("spc_settle_timer: SETTLE_CYCLES must be at least 1");
	end

	logic [CNT_W-1:0] count_q;

	// ----------------------------------------------------------------
	// Count while ready; any drop of ready restarts the wait
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_q <= CNT_ZERO;
			done_out <= 1'b0;
		end else if (!run_in || !osc_ready_in) begin
			count_q <= CNT_ZERO;
			done_out <= 1'b0;
		end else if (count_q == CNT_LAST) begin
			done_out <= 1'b1;
		end else begin
			count_q <= count_q + CNT_ONE;
		end
	end

endmodule // spc_settle_timer

`default_nettype wire

// ### spc_stop_mode_power_controller.sv
// Stop/halt power mode controller with register port and always-on enables
//
// Decided for this implementation: strobed register access and the register offsets.
`default_nettype none

module spc_stop_mode_power_controller
	import spc_pkg::*;
#(
	parameter int N_PERIPH = 8,
	parameter int SETTLE_CYCLES = spc_pkg::SETTLE_CYC
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic stop_instr_in,
	input wire logic halt_instr_in,
	input wire logic wdt_timeout_in,
	input wire logic wake_pin_in,
	input wire logic osc_ready_in,
	input wire logic bo_option_in,
	input wire spc_pkg::spc_bus_t bus_in,
	output logic [spc_pkg::DATA_W-1:0] rdata_out,
	output var spc_pkg::spc_mode_t mode_out,
	output var spc_pkg::spc_core_t core_out,
	output var spc_pkg::spc_keep_t keep_out,
	output logic [N_PERIPH-1:0] periph_en_out
);

	import spc_pkg::*;

	if (N_PERIPH < 1 || N_PERIPH > DATA_W) begin : g_chk
		$error("spc: N_PERIPH must lie between 1 and the data width");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	spc_mode_t state_q;
	spc_mode_t state_d;
	logic [DATA_W-1:0] osc_ctrl_q;
	logic [DATA_W-1:0] pwr_ctrl_q;
	logic [DATA_W-1:0] periph_dis_q;
	logic [DATA_W-1:0] stop_count_q;
	logic [2:0] pins_sync;
	logic wake_s;
	logic osc_rdy_s;
	logic bo_opt_s;
	logic bo_opt_q;
	logic settle_done;
	logic wake_evt;
	logic [N_PERIPH-1:0] periph_on;
	logic [DATA_W-1:0] status_word;

	// ----------------------------------------------------------------
	// Pin inputs
	// ----------------------------------------------------------------
	spc_sync3 #(
		.WIDTH(3)
	) u_sync (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in({bo_option_in, osc_ready_in, wake_pin_in}),
		.sync_out(pins_sync)
	);

	assign wake_s = pins_sync[0];
	assign osc_rdy_s = pins_sync[1];
	assign bo_opt_s = pins_sync[2];
	assign wake_evt = wake_s | wdt_timeout_in;

	// Option bit is static; register it through the sync on every cycle after reset release
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bo_opt_q <= 1'b0;
		end else begin
			bo_opt_q <= bo_opt_s;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator settle timer
	// ----------------------------------------------------------------
	spc_settle_timer #(
		.SETTLE_CYCLES(SETTLE_CYCLES)
	) u_settle (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.run_in(state_q == MODE_SETTLE),
		.osc_ready_in(osc_rdy_s),
		.done_out(settle_done)
	);

	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MODE_NORMAL: begin
				if (stop_instr_in) begin
					state_d = MODE_STOP;
				end else if (halt_instr_in) begin
					state_d = MODE_HALT;
				end
			end
			MODE_HALT: begin
				if (wake_evt) begin
					state_d = MODE_NORMAL;
				end
			end
			MODE_STOP: begin
				if (wake_evt) begin
					state_d = MODE_SETTLE;
				end
			end
			MODE_SETTLE: begin
				if (settle_done) begin
					state_d = MODE_NORMAL;
				end
			end
			default: begin
				state_d = MODE_NORMAL;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= MODE_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// Stop entries seen, wraps; gives software a trace of sleep activity
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stop_count_q <= ZERO_BYTE;
		end else if (state_q == MODE_NORMAL && state_d == MODE_STOP) begin
			stop_count_q <= stop_count_q + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			osc_ctrl_q <= OSC_CTRL_RST;
			pwr_ctrl_q <= PWR_CTRL_RST;
			periph_dis_q <= PERIPH_DIS_RST;
		end else if (bus_in.wr) begin
			unique case (bus_in.addr)
				ADDR_OSC_CTRL: osc_ctrl_q <= bus_in.wdata;
				ADDR_PWR_CTRL: pwr_ctrl_q <= bus_in.wdata;
				ADDR_PERIPH_DIS: periph_dis_q <= bus_in.wdata;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		status_word = ZERO_BYTE;
		status_word[STAT_MODE_LSB +: 4] = state_q;
		status_word[STAT_BO_OPT] = bo_opt_q;
		status_word[STAT_OSC_RDY] = osc_rdy_s;
	end

	// Read data stand only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= ZERO_BYTE;
		end else if (bus_in.rd) begin
			unique case (bus_in.addr)
				ADDR_OSC_CTRL: rdata_out <= osc_ctrl_q;
				ADDR_PWR_CTRL: rdata_out <= pwr_ctrl_q;
				ADDR_PERIPH_DIS: rdata_out <= periph_dis_q;
				ADDR_STATUS: rdata_out <= status_word;
				ADDR_STOP_COUNT: rdata_out <= stop_count_q;
				default: rdata_out <= ZERO_BYTE;
			endcase
		end else begin
			rdata_out <= ZERO_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Core clocking outputs (one cycle behind the mode)
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_out <= MODE_NORMAL;
			core_out <= '0;
		end else begin
			mode_out <= state_q;
			// oscillators off in stop; precision back on to settle, primary only with OSC_XTAL set
			core_out.primary_osc_en <= (state_q != MODE_STOP) && osc_ctrl_q[OSC_XTAL];
			core_out.precision_osc_en <= (state_q != MODE_STOP);
			// crystal pins released to GPIO in stop
			core_out.xtal_pin_en <= (state_q != MODE_STOP) && osc_ctrl_q[OSC_XTAL];
			core_out.sysclk_en <= (state_q == MODE_NORMAL) || (state_q == MODE_HALT);
			// core and program counter frozen outside normal
			core_out.cpu_run <= (state_q == MODE_NORMAL);
			core_out.pc_advance <= (state_q == MODE_NORMAL);
		end
	end

	// ----------------------------------------------------------------
	// Always-on functions
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			keep_out <= '0;
		end else begin
			keep_out.wdt_rc_osc_en <= osc_ctrl_q[OSC_WDT_RC];
			keep_out.wdt_logic_en <= pwr_ctrl_q[PWR_WDT_LOGIC] && osc_ctrl_q[OSC_WDT_RC];
			keep_out.sec_osc_en <= osc_ctrl_q[OSC_SEC];
			// stop timer counts on the secondary oscillator
			if (state_q == MODE_STOP || state_q == MODE_SETTLE) begin
				keep_out.stop_timer_run <= pwr_ctrl_q[PWR_TIMER_STOP] && osc_ctrl_q[OSC_SEC];
				keep_out.timer_clk_sec <= 1'b1;
			end else begin
				keep_out.stop_timer_run <= 1'b1;
				keep_out.timer_clk_sec <= 1'b0;
			end
			// brown-out kept in stop only by the option bit
			keep_out.bo_prot_en <= (state_q != MODE_STOP) || bo_opt_q;
			keep_out.lvd_en <= pwr_ctrl_q[PWR_LVD];
			keep_out.amp_cmp_en <= pwr_ctrl_q[PWR_AMP_CMP];
		end
	end

	// ----------------------------------------------------------------
	// Peripheral enables
	// ----------------------------------------------------------------
	for (genvar p = 0; p < N_PERIPH; p++) begin : g_periph
		// all idle in stop and while settling
		assign periph_on[p] = !periph_dis_q[p] &&
			(state_q == MODE_NORMAL || state_q == MODE_HALT);
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			periph_en_out <= '0;
		end else begin
			periph_en_out <= periph_on;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);

	AST_STOP_ENTRY: assert property (
		state_q == MODE_NORMAL && stop_instr_in |=> state_q == MODE_STOP ##1
		core_out.cpu_run == 1'b0)
		else $error("stop instruction did not enter stop");

	AST_MODE_ONEHOT: assert property (
		$onehot(state_q) && mode_out == $past(state_q))
		else $error("mode register not one-hot or output lags wrongly");

	AST_PERIPH_DISABLE: assert property (
		arst_n_in && state_q == MODE_NORMAL
		|=> periph_en_out == ~$past(periph_dis_q[N_PERIPH-1:0]))
		else $error("peripheral enable ignores its disable bit");

	AST_OSC_HALT: assert property (
		state_q == MODE_STOP |=> !core_out.primary_osc_en && !core_out.precision_osc_en)
		else $error("oscillator left running in stop");

	AST_XTAL_PINS: assert property (
		state_q == MODE_STOP [*2] |=> !core_out.xtal_pin_en)
		else $error("crystal pins still enabled in stop");

	AST_SYSCLK_GATED: assert property (
		state_q == MODE_STOP || state_q == MODE_SETTLE |=> !core_out.sysclk_en)
		else $error("system clock running in stop");

	AST_CORE_FROZEN: assert property (
		state_q != MODE_NORMAL |=> !core_out.cpu_run && !core_out.pc_advance)
		else $error("core or program counter running outside normal");

	AST_WDT_RC: assert property (
		state_q == MODE_STOP |=> keep_out.wdt_rc_osc_en == $past(osc_ctrl_q[OSC_WDT_RC]))
		else $error("watchdog RC enable wrong in stop");

	AST_WDT_LOGIC: assert property (
		state_q == MODE_STOP && pwr_ctrl_q[PWR_WDT_LOGIC] && osc_ctrl_q[OSC_WDT_RC]
		|=> keep_out.wdt_logic_en)
		else $error("watchdog logic stopped while enabled");

	AST_SEC_OSC: assert property (
		state_q == MODE_STOP && osc_ctrl_q[OSC_SEC] |=> keep_out.sec_osc_en)
		else $error("secondary oscillator stopped while enabled");

	AST_STOP_TIMER: assert property (
		state_q == MODE_STOP |=> keep_out.timer_clk_sec &&
		keep_out.stop_timer_run == ($past(pwr_ctrl_q[PWR_TIMER_STOP]) &&
		$past(osc_ctrl_q[OSC_SEC])))
		else $error("stop timer clocking wrong");

	AST_BROWN_OUT: assert property (
		state_q == MODE_STOP |=> keep_out.bo_prot_en == $past(bo_opt_q))
		else $error("brown-out protection ignores its option bit");

	AST_LVD: assert property (
		state_q == MODE_STOP |=> keep_out.lvd_en == $past(pwr_ctrl_q[PWR_LVD]))
		else $error("low-voltage detect enable wrong in stop");

	AST_AMP_CMP: assert property (
		state_q == MODE_STOP |=> keep_out.amp_cmp_en == $past(pwr_ctrl_q[PWR_AMP_CMP]))
		else $error("op-amp and comparator enable wrong in stop");

	AST_PERIPH_IDLE: assert property (
		state_q == MODE_STOP |=> periph_en_out == '0)
		else $error("peripheral enabled during stop");

	AST_SETTLE_HOLD: assert property (
		state_q == MODE_STOP && wake_evt |=> state_q == MODE_SETTLE [*2] ##1
		!core_out.sysclk_en && core_out.precision_osc_en)
		else $error("core released before oscillators settled");

	AST_SETTLE_EXIT: assert property (
		state_q == MODE_SETTLE && settle_done |=> state_q == MODE_NORMAL ##1
		core_out.sysclk_en && core_out.cpu_run)
		else $error("settled oscillator did not release the core");

	COV_STOP: cover property (state_q == MODE_NORMAL ##1 state_q == MODE_STOP);
	COV_WAKE: cover property (state_q == MODE_SETTLE ##1 state_q == MODE_NORMAL);
	COV_HALT: cover property (state_q == MODE_HALT ##1 state_q == MODE_NORMAL);

endmodule // spc_stop_mode_power_controller

`default_nettype wire

// ### spc_stop_mode_power_controller_tb.sv
// Self-checking testbench for the stop-mode power controller
`default_nettype none

module spc_stop_mode_power_controller_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import spc_pkg::*;

	localparam int SETT = 4;
	typedef struct {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} spc_row_t;

	logic clock_in = 1'b0;
	logic arst_n = 1'b0;
	logic stop_instr = 1'b0;
	logic halt_instr = 1'b0;
	logic wdt_to = 1'b0;
	logic wake_pin = 1'b0;
	logic osc_rdy = 1'b1;
	logic bo_opt = 1'b1;
	spc_bus_t bus = '0;
	logic [7:0] rdata;
	spc_mode_t mode;
	spc_core_t core;
	spc_keep_t keep;
	logic [7:0] periph;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	spc_row_t rows [11];

	spc_stop_mode_power_controller #(.N_PERIPH(8), .SETTLE_CYCLES(SETT)) u_dut (
		.clock_in(clock_in),
		.arst_n_in(arst_n),
		.stop_instr_in(stop_instr),
		.halt_instr_in(halt_instr),
		.wdt_timeout_in(wdt_to),
		.wake_pin_in(wake_pin),
		.osc_ready_in(osc_rdy),
		.bo_option_in(bo_opt),
		.bus_in(bus),
		.rdata_out(rdata),
		.mode_out(mode),
		.core_out(core),
		.keep_out(keep),
		.periph_en_out(periph)
	);

	always #4 clock_in = ~clock_in;

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hang guard well above the under two hundred cycles the sequence needs
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Bus and mode helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock_in);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock_in);
		bus <= '0;
		#1;
		check("rdata", rdata, exp);
		@(posedge clock_in);
		#1;
		check("rdata_idle", rdata, 8'h00);
	endtask

	// Pulse stop or halt for one cycle, then look where outputs have settled
	task automatic go(input logic s, input logic h);
		@(posedge clock_in);
		stop_instr <= s;
		halt_instr <= h;
		@(posedge clock_in);
		stop_instr <= 1'b0;
		halt_instr <= 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
	endtask

	task automatic wait_mode(input spc_mode_t m, input int lim, output int k);
		k = 0;
		while (mode !== m && k < lim) begin
			@(posedge clock_in);
			#1;
			k++;
		end
		check("mode_wait", mode, m);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rows = '{
			'{1'b0, 8'h00, 8'h00, 8'h01}, '{1'b0, 8'h01, 8'h00, 8'h04},
			'{1'b0, 8'h02, 8'h00, 8'h00}, '{1'b0, 8'h03, 8'h00, 8'h31},
			'{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h00},
			'{1'b1, 8'h00, 8'h03, 8'h03}, '{1'b1, 8'h01, 8'h0F, 8'h0F},
			'{1'b1, 8'h02, 8'h05, 8'h05}, '{1'b1, 8'h03, 8'hFF, 8'h31},
			'{1'b1, 8'h10, 8'hAA, 8'h00}};
		repeat (2) @(posedge clock_in);
		arst_n <= 1'b1;
		repeat (8) @(posedge clock_in);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].addr, rows[i].wdata);
			end
			rd(rows[i].addr, rows[i].exp); // register port
		end
		check("periph_normal", periph, 8'hFA); // mask applies
		check("core_normal", core, 6'h17); // normal running
		// Halt keeps the mask and refuses a stop
		go(1'b0, 1'b1);
		check("mode_halt", mode, MODE_HALT); // halt entered
		check("periph_halt", periph, 8'hFA); // mask in halt
		go(1'b1, 1'b0);
		check("mode_halt_hold", mode, MODE_HALT); // stop only from normal
		@(posedge clock_in);
		wdt_to <= 1'b1;
		@(posedge clock_in);
		wdt_to <= 1'b0;
		wait_mode(MODE_NORMAL, 6, n); // halt wake
		// Stop with every keep-alive enabled
		go(1'b1, 1'b0);
		check("mode_stop", mode, MODE_STOP); // stop entered
		check("core_stop", core, 6'h00); // all off
		check("periph_stop", periph, 8'h00); // others idle
		check("keep_stop", keep, 8'hFF); // kept
		@(posedge clock_in);
		osc_rdy <= 1'b0;
		wake_pin <= 1'b1;
		wait_mode(MODE_SETTLE, 12, n);
		@(posedge clock_in);
		wake_pin <= 1'b0;
		repeat (20) @(posedge clock_in);
		#1;
		check("mode_settle", mode, MODE_SETTLE); // wait for oscillator
		check("sysclk_settle", core.sysclk_en, 1'b0); // clock held
		check("prec_settle", core.precision_osc_en, 1'b1); // restart
		check("periph_settle", periph, 8'h00); // idle while settling
		@(posedge clock_in);
		osc_rdy <= 1'b1;
		wait_mode(MODE_NORMAL, 30, n);
		check("settle_len", n >= SETT + 1 && n <= SETT + 14, 1'b1); // counted settle
		@(posedge clock_in);
		#1;
		check("core_wake", core, 6'h17); // clock and core released
		// Stop with every keep-alive disabled
		@(posedge clock_in);
		bo_opt <= 1'b0;
		wr(ADDR_OSC_CTRL, 8'h00);
		wr(ADDR_PWR_CTRL, 8'h00);
		repeat (8) @(posedge clock_in);
		go(1'b1, 1'b0);
		check("keep_off", keep & 8'hF7, 8'h00); // off
		@(posedge clock_in);
		wdt_to <= 1'b1;
		@(posedge clock_in);
		wdt_to <= 1'b0;
		wait_mode(MODE_SETTLE, 6, n);
		wait_mode(MODE_NORMAL, 30, n); // wake via watchdog
		rd(ADDR_STOP_COUNT, 8'h02);
		// Reset in the middle of a stop
		go(1'b1, 1'b0);
		@(posedge clock_in);
		arst_n <= 1'b0;
		#1;
		check("mode_rst", mode, MODE_NORMAL);
		check("core_rst", core, 6'h00);
		check("periph_rst", periph, 8'h00);
		repeat (2) @(posedge clock_in);
		arst_n <= 1'b1;
		@(posedge clock_in);
		@(posedge clock_in);
		#1;
		check("core_rel", core, 6'h17);
		check("periph_rel", periph, 8'hFF);
		check("keep_rel", keep, 8'hD4);
		repeat (6) @(posedge clock_in);
		rd(ADDR_OSC_CTRL, 8'h01);
		rd(ADDR_STOP_COUNT, 8'h00);
		finish_test();
	end

endmodule // spc_stop_mode_power_controller_tb

`default_nettype wire

// ### spc_sync3.sv
// Three-stage synchroniser with agreement filter, one lane per bit
`default_nettype none

module spc_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	if (WIDTH < 1) begin : g_chk
		$error("spc_sync3: WIDTH must be at least 1");
	end

	// ----------------------------------------------------------------
	// Per-bit lanes
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_lane
		logic s1_q;
		logic s2_q;
		logic s3_q;
		always_ff @(posedge clock_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				s1_q <= async_in[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				// Only a level seen twice in a row counts
				if (s2_q == s3_q) begin
					sync_out[i] <= s3_q;
				end
			end
		end
	end

endmodule // spc_sync3

`default_nettype wire
